// ### adc_serial_pkg.sv
// Purpose: Shared constants and types of the serial result port
// Assumes: 32-bit AXI4-Lite register access, 250 MHz aclk
// Notes: Offsets are byte addresses
package adc_serial_pkg;
  localparam int RES_W = 18;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h11;
  localparam logic [4:0] FRAME_BITS = 5'h12;
  localparam logic [1:0] SERIAL_MODE = 2'h3;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INT_STATUS_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  // Control fields
  localparam int CTRL_W = 7;
  localparam int SEL_LSB = 0;
  localparam int POL_BIT = 2;
  localparam int SRC_BIT = 3;
  localparam int RDC_BIT = 4;
  localparam int CODE_BIT = 5;
  localparam int FPOL_BIT = 6;
  localparam logic [6:0] CTRL_RESET = 7'h03;
  // Interrupt bits
  localparam int INT_W = 3;
  localparam int DONE_BIT = 0;
  localparam int ERR_BIT = 1;
  localparam int LOAD_BIT = 2;
  localparam logic [2:0] INT_RESET = 3'h0;
  // Quarter periods of the generated clock, in aclk cycles
  localparam int QUARTER_RAC_CYC = 4;
  localparam int QUARTER_RDC_CYC = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {ST_IDLE, ST_SHIFT} frame_state_type;
endpackage : adc_serial_pkg

// ### shift_bus_if.sv
// Purpose: Link between frame control and the result shift register
// Assumes: One producer, one shift register
// Notes: msb is the bit currently on the serial line
`timescale 1ns/1ps
interface shift_bus_if;
  logic load;
  logic [adc_serial_pkg::RES_W-1:0] load_data;
  logic advance;
  logic fill_bit;
  logic msb;
  modport ctrl (output load, output load_data, output advance, output fill_bit, input msb);
  modport store (input load, input load_data, input advance, input fill_bit, output msb);
endinterface : shift_bus_if

// ### pin_sync.sv
// Purpose: Two-flop synchronisers for pin inputs
// Assumes: Inputs asynchronous to aclk
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins in, levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_ff;
      logic stable_ff;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_ff <= INIT[i];
          stable_ff <= INIT[i];
        end else begin
          meta_ff <= pin_in[i];
          stable_ff <= meta_ff;
        end
      end
      assign level_out[i] = stable_ff;
    end
  endgenerate
endmodule : pin_sync

// ### result_shifter.sv
// Purpose: Result shift register, MSB first, with chain fill
// Assumes: load and advance never together
// Notes: Chain bits enter at the bottom
`timescale 1ns/1ps
module result_shifter #(
  parameter int WIDTH = adc_serial_pkg::RES_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control side
  shift_bus_if.store bus
);
  initial begin
    if (WIDTH != adc_serial_pkg::RES_W) $error("result_shifter width must match the result");
  end
  logic [WIDTH-1:0] sr_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_ff <= '0;
    end else if (bus.load) begin
      sr_ff <= bus.load_data;
    end else if (bus.advance) begin
      sr_ff <= {sr_ff[WIDTH-2:0], bus.fill_bit}; // R05
    end
  end
  assign bus.msb = sr_ff[WIDTH-1]; // R06
  a_msb_first_load: assert property (@(posedge aclk) disable iff (!aresetn) // R06
    bus.load |=> bus.msb == $past(bus.load_data[WIDTH-1]))
    else $error("msb not first after load");
endmodule : result_shifter

// ### adc_serial_result_port.sv
// Purpose: Serial result port of an 18-bit converter, AXI4-Lite control
// Assumes: conv_start and conv_done are one-cycle pulses on aclk
// Notes: Link clock is sampled, never used as a clock
// Notes on behaviour
// R01 - In serial mode the polarity select inverts the serial clock in every sub-mode.
// R02 - Outside serial mode the shared pins carry parallel result bits 9, 10 and 11.
// R03 - Master with read-during-conversion shifts the previous result during conversion at a faster clock.
// R04 - Master with read-after-conversion shifts the current result only once conversion ends.
// R05 - In slave mode the chain input reaches the data output 18 clock periods after read start.
// R06 - Results sit in a shift register, leave MSB first, coded by the coding select.
// R07 - In master mode each data bit is stable across both edges of the generated clock.
// R08 - Slave with polarity low updates data on rising edges; the host samples on falling ones.
// R09 - Slave with polarity high updates data on falling edges; the host samples on rising ones.
// R10 - The clock source select makes the clock pin an output or an input.
// R11 - Read mode selection applies only in master mode.
// R12 - With clock source low the port is master and drives its own clock.
// R13 - With clock source high the host clock, gated by chip select, paces the data.
// R14 - In master mode the frame marker is active at its polarity while data is valid.
// R15 - In slave mode an unfinished read at conversion end is dropped and the error flag pulses.
// R16 - A frame is 18 bits, one per clock period, without gaps.
`timescale 1ns/1ps
module adc_serial_result_port #(
  parameter int ADDR_W = 8,
  parameter int QUARTER_RAC = adc_serial_pkg::QUARTER_RAC_CYC,
  parameter int QUARTER_RDC = adc_serial_pkg::QUARTER_RDC_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Converter core
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic [adc_serial_pkg::RES_W-1:0] conv_result,
  // Pins
  input wire logic cs_n_pin,
  input wire logic rd_n_pin,
  input wire logic sclk_pin_in,
  output logic sclk_pin_out,
  output logic sclk_pin_oe,
  input wire logic pin9_in,
  output logic pin9_out,
  output logic pin9_oe,
  output logic serial_result_out,
  output logic frame_marker_out,
  output logic incomplete_read_flag,
  // Interrupt
  output logic irq
);
  initial begin
    if (ADDR_W < 5) $error("address too narrow for the register map");
    if (QUARTER_RAC < 1 || QUARTER_RAC > 255) $error("QUARTER_RAC out of range");
    if (QUARTER_RDC < 1 || QUARTER_RDC > 255) $error("QUARTER_RDC out of range");
  end

  function automatic logic [adc_serial_pkg::RES_W-1:0] apply_coding(
    input logic [adc_serial_pkg::RES_W-1:0] raw, input logic straight);
    // Core delivers straight binary; two's complement flips the top bit
    apply_coding = {raw[adc_serial_pkg::RES_W-1] ^ ~straight, raw[adc_serial_pkg::RES_W-2:0]};
  endfunction : apply_coding

  shift_bus_if sbus ();
  result_shifter #(.WIDTH(adc_serial_pkg::RES_W)) u_shifter (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(sbus.store)
  );

  // Pin synchronisers: cs, rd, chain, sclk
  logic [3:0] pins_s;
  pin_sync #(.WIDTH(4), .INIT(4'hE)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in({cs_n_pin, rd_n_pin, pin9_in, sclk_pin_in}),
    .level_out(pins_s)
  );

  logic [adc_serial_pkg::CTRL_W-1:0] ctrl_ff;
  logic [adc_serial_pkg::INT_W-1:0] int_status_ff;
  logic [adc_serial_pkg::INT_W-1:0] int_mask_ff;
  logic [adc_serial_pkg::RES_W-1:0] result_ff;
  adc_serial_pkg::frame_state_type state_ff, nxt_state;
  logic [adc_serial_pkg::CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] qcnt_ff;
  logic [1:0] phase_ff;
  logic sclk_prev_ff;
  logic read_en_prev_ff;
  logic chain_ff;

  wire serial = ctrl_ff[adc_serial_pkg::SEL_LSB +: 2] == adc_serial_pkg::SERIAL_MODE;
  wire pol = ctrl_ff[adc_serial_pkg::POL_BIT];
  wire slave = ctrl_ff[adc_serial_pkg::SRC_BIT];
  wire read_during_conversion = ctrl_ff[adc_serial_pkg::RDC_BIT];
  wire fpol = ctrl_ff[adc_serial_pkg::FPOL_BIT];
  wire read_en = !pins_s[3] && !pins_s[2];
  wire shifting = state_ff == adc_serial_pkg::ST_SHIFT;
  wire master_act = serial && !slave;
  wire slave_act = serial && slave;

  // Host clock edges, polarity folded in
  wire eff_clk = pins_s[0] ^ pol; // R01
  wire eff_prev = sclk_prev_ff ^ pol;
  wire upd_edge = read_en && eff_clk && !eff_prev; // R08 R09 R13
  wire smp_edge = read_en && !eff_clk && eff_prev;

  logic [7:0] q_last;
  assign q_last = read_during_conversion ? 8'(QUARTER_RDC - 1) : 8'(QUARTER_RAC - 1); // R03
  wire int_clk = phase_ff == 2'h1 || phase_ff == 2'h2;
  wire boundary = master_act && shifting && qcnt_ff == q_last && phase_ff == 2'h3;
  wire at_last = bit_cnt_ff == adc_serial_pkg::LAST_BIT;

  // Read mode only matters to the master
  wire master_start = master_act && read_en && (read_during_conversion ? conv_start : conv_done); // R03 R04 R11
  wire slave_start = slave_act && read_en && !read_en_prev_ff;
  wire slave_err = conv_done && slave_act && shifting
    && bit_cnt_ff < adc_serial_pkg::FRAME_BITS; // R15
  wire frame_done = shifting && ((boundary && at_last) || (slave_act && upd_edge && at_last)); // R16

  // Host clock history and chain sampling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_prev_ff <= 1'b0;
      read_en_prev_ff <= 1'b0;
      chain_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= pins_s[0];
      read_en_prev_ff <= read_en;
      // Read start primes the first fill bit; no sample edge precedes it
      if (smp_edge || slave_start) begin
        chain_ff <= pins_s[1]; // R05
      end
    end
  end

  // Frame sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    case (state_ff)
      adc_serial_pkg::ST_IDLE: begin
        if (master_start || slave_start) begin
          nxt_state = adc_serial_pkg::ST_SHIFT;
          nxt_bit_cnt = '0;
        end
      end
      adc_serial_pkg::ST_SHIFT: begin
        if (!serial) begin
          nxt_state = adc_serial_pkg::ST_IDLE; // R02
        end else if (!slave) begin
          if (boundary && at_last) begin
            nxt_state = adc_serial_pkg::ST_IDLE; // R16
          end else if (boundary) begin
            nxt_bit_cnt = bit_cnt_ff + 5'h01;
          end
        end else if (!read_en) begin
          nxt_state = adc_serial_pkg::ST_IDLE; // R13
        end else if (slave_err) begin
          nxt_bit_cnt = '0; // R15
        end else if (upd_edge && bit_cnt_ff < adc_serial_pkg::FRAME_BITS) begin
          nxt_bit_cnt = bit_cnt_ff + 5'h01;
        end
      end
      default: begin
        nxt_state = adc_serial_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= adc_serial_pkg::ST_IDLE;
      bit_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
    end
  end

  // Generated clock: data moves mid-low phase, clear of both edges
  always_ff @(posedge aclk) begin
    if (!aresetn || !shifting || !master_act) begin
      qcnt_ff <= '0;
      phase_ff <= '0;
    end else if (qcnt_ff == q_last) begin
      qcnt_ff <= '0;
      phase_ff <= phase_ff + 2'h1; // R07 R12
    end else begin
      qcnt_ff <= qcnt_ff + 8'h01;
    end
  end

  // Shift register control
  assign sbus.load = conv_done && (!shifting || slave_err
    || (slave_act && bit_cnt_ff >= adc_serial_pkg::FRAME_BITS)); // R06 R15
  assign sbus.load_data = apply_coding(conv_result, ctrl_ff[adc_serial_pkg::CODE_BIT]); // R06
  assign sbus.advance = !sbus.load && shifting
    && ((boundary && !at_last) || (slave_act && upd_edge)); // R07 R08 R09
  assign sbus.fill_bit = chain_ff; // R05

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_ff <= '0;
    end else if (conv_done) begin
      result_ff <= sbus.load_data;
    end
  end

  // Pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_result_out <= 1'b0;
      sclk_pin_out <= 1'b0;
      sclk_pin_oe <= 1'b0;
      pin9_out <= 1'b0;
      pin9_oe <= 1'b0;
      frame_marker_out <= 1'b0;
      incomplete_read_flag <= 1'b0;
    end else if (serial) begin
      serial_result_out <= shifting && sbus.msb; // R06
      sclk_pin_out <= int_clk ^ pol; // R01
      sclk_pin_oe <= !slave; // R10 R12
      pin9_out <= 1'b0;
      pin9_oe <= 1'b0;
      frame_marker_out <= (master_act && shifting) ^ fpol; // R14
      incomplete_read_flag <= slave_err; // R15
    end else begin
      serial_result_out <= result_ff[10]; // R02
      sclk_pin_out <= result_ff[11];
      sclk_pin_oe <= 1'b1;
      pin9_out <= result_ff[9];
      pin9_oe <= 1'b1;
      frame_marker_out <= 1'b0;
      incomplete_read_flag <= 1'b0;
    end
  end

  // AXI4-Lite write path
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] waddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  wire aw_hs = awvalid && awready;
  wire w_hs = wvalid && wready;
  wire do_write = aw_held_ff && w_held_ff && !bvalid;
  wire wr_ok = waddr_ff <= ADDR_W'(adc_serial_pkg::RESULT_OFS);
  wire wr_ctrl = do_write && wstrb_ff[0] && waddr_ff == ADDR_W'(adc_serial_pkg::CTRL_OFS);
  wire wr_clr = do_write && wstrb_ff[0] && waddr_ff == ADDR_W'(adc_serial_pkg::INT_STATUS_OFS);
  wire wr_mask = do_write && wstrb_ff[0] && waddr_ff == ADDR_W'(adc_serial_pkg::INT_MASK_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      waddr_ff <= '0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else begin
      if (aw_hs) begin
        aw_held_ff <= 1'b1;
        waddr_ff <= {awaddr[ADDR_W-1:2], 2'h0};
      end else if (do_write) begin
        aw_held_ff <= 1'b0;
      end
      if (w_hs) begin
        w_held_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end else if (do_write) begin
        w_held_ff <= 1'b0;
      end
      awready <= !(aw_hs || (aw_held_ff && !do_write));
      wready <= !(w_hs || (w_held_ff && !do_write));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= adc_serial_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? adc_serial_pkg::RESP_OKAY : adc_serial_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control, mask and sticky events
  logic [adc_serial_pkg::INT_W-1:0] events, nxt_int_status;
  assign events = {conv_done, slave_err, frame_done};
  // Set beats clear in the same cycle
  assign nxt_int_status = (int_status_ff & ~(wr_clr ? wdata_ff[adc_serial_pkg::INT_W-1:0] : '0)) | events;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= adc_serial_pkg::CTRL_RESET;
      int_mask_ff <= adc_serial_pkg::INT_RESET;
      int_status_ff <= adc_serial_pkg::INT_RESET;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata_ff[adc_serial_pkg::CTRL_W-1:0];
      end
      if (wr_mask) begin
        int_mask_ff <= wdata_ff[adc_serial_pkg::INT_W-1:0];
      end
      int_status_ff <= nxt_int_status;
      irq <= |(nxt_int_status & int_mask_ff);
    end
  end

  // AXI4-Lite read path
  logic [31:0] rd_word;
  logic rd_ok;
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    case ({araddr[ADDR_W-1:2], 2'h0})
      ADDR_W'(adc_serial_pkg::CTRL_OFS): rd_word = 32'(ctrl_ff);
      ADDR_W'(adc_serial_pkg::STATUS_OFS): rd_word = 32'({bit_cnt_ff, shifting});
      ADDR_W'(adc_serial_pkg::INT_STATUS_OFS): rd_word = 32'(int_status_ff);
      ADDR_W'(adc_serial_pkg::INT_MASK_OFS): rd_word = 32'(int_mask_ff);
      ADDR_W'(adc_serial_pkg::RESULT_OFS): rd_word = 32'(result_ff);
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= adc_serial_pkg::RESP_OKAY;
    end else begin
      arready <= !((arvalid && arready) || (rvalid && !rready));
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? adc_serial_pkg::RESP_OKAY : adc_serial_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Checks
  a_parallel_pins: assert property (@(posedge aclk) disable iff (!aresetn) // R02
    !serial |=> sclk_pin_oe && pin9_oe && serial_result_out == $past(result_ff[10]))
    else $error("shared pins not carrying parallel bits");
  a_sclk_invert: assert property (@(posedge aclk) disable iff (!aresetn) // R01
    serial |=> sclk_pin_out == ($past(int_clk) ^ $past(pol)))
    else $error("serial clock polarity wrong");
  a_clock_dir: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    serial |=> sclk_pin_oe == !$past(slave))
    else $error("clock pin direction wrong");
  a_frame_marker: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    master_act && shifting |=> frame_marker_out == !$past(fpol))
    else $error("frame marker not active during frame");
  a_master_stable: assert property (@(posedge aclk) disable iff (!aresetn) // R07
    master_act && shifting && int_clk |-> !sbus.advance && !sbus.load)
    else $error("master data moved near a clock edge");
  a_read_error: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    incomplete_read_flag |-> $past(conv_done) && $past(slave_act) ##1 !incomplete_read_flag)
    else $error("read error flag without cause or too long");
  a_rdc_start: assert property (@(posedge aclk) disable iff (!aresetn) // R03
    master_act && read_during_conversion && conv_start && read_en && !shifting |=> shifting [*4])
    else $error("read during conversion did not start");
  a_rac_wait: assert property (@(posedge aclk) disable iff (!aresetn) // R04
    master_act && !read_during_conversion && !shifting && !conv_done |=> !shifting)
    else $error("read after conversion started early");
  a_slave_edge: assert property (@(posedge aclk) disable iff (!aresetn) // R08
    slave_act && sbus.advance |-> $past(eff_clk) == 1'b0 && eff_clk)
    else $error("slave data moved on the wrong edge");
  a_int_sticky: assert property (@(posedge aclk) disable iff (!aresetn) // R16
    frame_done |=> int_status_ff[adc_serial_pkg::DONE_BIT])
    else $error("frame done event lost");
endmodule : adc_serial_result_port

// ### serial_host_model.sv
// Purpose: Host side of the serial result link
// Assumes: Bench calls the tasks; device pins sampled on aclk
// Notes: Host clock stands still outside slave reads
`timescale 1ns/1ps
module serial_host_model (
  // Clock
  input wire logic aclk,
  // Device pins
  input wire logic pol,
  input wire logic sclk_pin_out,
  input wire logic sclk_pin_oe,
  input wire logic serial_result_out,
  // Host pins
  output logic cs_n,
  output logic rd_n,
  output logic sclk,
  output logic chain
);
  logic [19:0] cap = '0;
  int nbits = 0;
  int per = 0;
  int cyc = 0;
  logic prev = 1'b0;

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    sclk = 1'b0;
    chain = 1'b1;
  end

  // Mid-bit sampling where the uninverted clock rises
  always @(posedge aclk) begin
    prev <= sclk_pin_out ^ pol;
    cyc <= cyc + 1;
    if (sclk_pin_oe && !prev && (sclk_pin_out ^ pol)) begin
      cap <= {cap[18:0], serial_result_out};
      nbits <= nbits + 1;
      per <= cyc + 1;
      cyc <= 0;
    end
  end

  task automatic select(input logic v);
    @(posedge aclk);
    cs_n <= v;
    rd_n <= v;
  endtask : select

  task automatic slave_read(input int n, input logic p);
    @(posedge aclk);
    sclk <= p;
    repeat (8) @(posedge aclk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    // Long set-up, read enable crosses a synchroniser
    repeat (40) @(posedge aclk);
    cap <= {cap[18:0], serial_result_out};
    nbits <= nbits + 1;
    for (int i = 1; i < n; i++) begin
      sclk <= ~p;
      repeat (20) @(posedge aclk);
      sclk <= p;
      cap <= {cap[18:0], serial_result_out};
      nbits <= nbits + 1;
      repeat (20) @(posedge aclk);
    end
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask : slave_read
endmodule : serial_host_model

// ### adc_serial_result_port_bench.sv
// Purpose: Self-checking bench of the serial result port
// Assumes: Default quarter periods, 250 MHz aclk
// Notes: Host model plays the far side of the link
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module adc_serial_result_port_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic conv_start = 1'b0, conv_done = 1'b0;
  logic [17:0] conv_result = '0;
  logic awready, wready, bvalid, arready, rvalid, sclk_pin_out, sclk_pin_oe, pin9_out, pin9_oe;
  logic serial_result_out, frame_marker_out, incomplete_read_flag, irq, cs_n, rd_n, sclk, chain;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [6:0] cfg = 7'h03;
  logic [17:0] res, ex;
  logic err_seen = 1'b0;
  int errors = 0;
  int n_tests = 0;

  always #2 aclk = ~aclk;

  adc_serial_result_port i_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .conv_start, .conv_done,
    .conv_result, .cs_n_pin(cs_n), .rd_n_pin(rd_n), .sclk_pin_in(sclk), .sclk_pin_out, .sclk_pin_oe,
    .pin9_in(chain), .pin9_out, .pin9_oe, .serial_result_out, .frame_marker_out, .incomplete_read_flag, .irq
  );

  serial_host_model i_host (
    .aclk, .pol(cfg[adc_serial_pkg::POL_BIT]), .sclk_pin_out, .sclk_pin_oe, .serial_result_out,
    .cs_n, .rd_n, .sclk, .chain
  );

  always @(posedge aclk) if (incomplete_read_flag === 1'b1) err_seen <= 1'b1;

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && awready === 1'b1) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    r = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd

  task automatic conv(input logic start, input logic [17:0] v);
    @(posedge aclk);
    conv_result <= v;
    conv_start <= start;
    conv_done <= !start;
    @(posedge aclk);
    conv_start <= 1'b0;
    conv_done <= 1'b0;
  endtask : conv

  task automatic end_of_test;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Generous bound, the tests need some 2,500 cycles
  initial begin
    #100000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(adc_serial_pkg::CTRL_OFS);
    `CHK(d, 32'h3)
    `CHK(sclk_pin_oe, 1'b1)
    rd(8'h14);
    `CHK({r, d}, {adc_serial_pkg::RESP_SLVERR, 32'h0})
    wr(8'h14, 32'h0);
    `CHK(r, adc_serial_pkg::RESP_SLVERR)
    wr(adc_serial_pkg::INT_MASK_OFS, 32'h1);
    `CHK(r, adc_serial_pkg::RESP_OKAY)
    i_host.select(1'b0);
    // Read-after with polarity low, then read-during with every option but the clock source inverted
    for (int k = 0; k < 2; k++) begin
      cfg = k ? 7'h77 : 7'h03;
      res = k ? 18'h2A5C3 : 18'h1B4E9;
      ex = k ? res : res ^ 18'h20000;
      wr(adc_serial_pkg::CTRL_OFS, {25'h0, cfg});
      i_host.nbits = 0;
      conv(1'b0, res);
      if (k) conv(1'b1, 18'h0);
      repeat (20) @(posedge aclk);
      `CHK(frame_marker_out, ~cfg[6])
      while (i_host.nbits < 18) @(posedge aclk);
      repeat (16) @(posedge aclk);
      `CHK(frame_marker_out, cfg[6])
      `CHK(i_host.cap[17:0], ex)
      `CHK(i_host.per, k ? 8 : 16)
      `CHK(irq, 1'b1)
      wr(adc_serial_pkg::INT_STATUS_OFS, 32'h7);
      repeat (2) @(posedge aclk);
      `CHK(irq, 1'b0)
      rd(adc_serial_pkg::RESULT_OFS);
      `CHK(d[17:0], ex)
    end
    i_host.select(1'b1);
    for (int p = 0; p < 2; p++) begin
      cfg = {4'h5, p[0], 2'h3};
      res = p ? 18'h0F0F1 : 18'h3C96A;
      wr(adc_serial_pkg::CTRL_OFS, {25'h0, cfg});
      conv(1'b0, res);
      i_host.nbits = 0;
      i_host.slave_read(20, p[0]);
      `CHK(i_host.cap, {res, 2'b11})
      `CHK(sclk_pin_oe, 1'b0)
    end
    // Conversion ends in mid-read
    fork
      i_host.slave_read(6, 1'b1);
      begin
        repeat (150) @(posedge aclk);
        conv(1'b0, 18'h12345);
      end
    join
    `CHK(err_seen, 1'b1)
    rd(adc_serial_pkg::INT_STATUS_OFS);
    `CHK(d[adc_serial_pkg::ERR_BIT], 1'b1)
    wr(adc_serial_pkg::CTRL_OFS, 32'h20);
    conv(1'b0, 18'h00A00);
    repeat (4) @(posedge aclk);
    `CHK({sclk_pin_oe, sclk_pin_out, serial_result_out, pin9_out, pin9_oe}, 5'h1B)
    end_of_test();
  end
endmodule : adc_serial_result_port_bench
